//--- design/amx_params.svh
// Constants of the audio matrix mixer: sizes, register map, fields, resets.
// Definitions only; included by the package and every design file.
`ifndef AMX_PARAMS_SVH
`define AMX_PARAMS_SVH
`define AMX_NCH        12
`define AMX_NSRC       24
`define AMX_NMET       36
`define AMX_SW         24
`define AMX_GW         16
`define AMX_AW         10
`define AMX_REG_CTRL   10'h000
`define AMX_REG_STAT   10'h001
`define AMX_REG_FXSND  10'h002
`define AMX_REG_FXRET  10'h003
`define AMX_REG_FXFB   10'h004
`define AMX_BASE_OGAIN 10'h010
`define AMX_BASE_EQ    10'h040
`define AMX_END_EQ     10'h070
`define AMX_BASE_PEAK  10'h080
`define AMX_BASE_RMS   10'h0C0
`define AMX_BASE_XP    10'h100
`define AMX_END_XP     10'h280
`define AMX_CTRL_RECEQ 0
`define AMX_CTRL_LOOP  1
`define AMX_CTRL_SPDIF 2
`define AMX_CTRL_FX    3
`define AMX_CTRL_RST   4'h0
`define AMX_GAIN_RST   16'h0000
`define AMX_UNITY      16'h8000
`define AMX_SMAX       24'h7FFFFF
`define AMX_SMIN       24'h800000
`define AMX_GSHIFT     15
`define AMX_SQSHIFT    23
`define AMX_RMS_SHIFT  8
`define AMX_LC_SHIFT   8
`define AMX_LO_SHIFT   5
`define AMX_HI_SHIFT   2
`define AMX_OPT_BASE   4
`define AMX_OPT_KEEP   2
`define AMX_FX_DEPTH   64
`endif

//--- design/amx_pkg.sv
// Types and arithmetic helpers shared by the mixer files.
// Relies on amx_params.svh for every size.
`include "amx_params.svh"
package amx_pkg;
  typedef logic signed [`AMX_SW-1:0] amx_sample_t;
  typedef amx_sample_t [`AMX_NCH-1:0] amx_frame_t;
  typedef logic [`AMX_GW-1:0] amx_gain_t;
  typedef struct packed {
    logic [`AMX_AW-1:0] addr;
    logic [31:0]        wdata;
    logic               wr;
    logic               rd;
  } amx_reg_req_t;
  typedef enum logic [1:0] {AMX_IDLE, AMX_MIX, AMX_OUTG, AMX_DONE} amx_state_t;

  // Clip a wide value to the sample range
  function automatic amx_sample_t amx_sat(input logic signed [47:0] v);
    if (v > $signed(48'(`AMX_SMAX))) return `AMX_SMAX;
    if (v < $signed({{24{1'b1}}, `AMX_SMIN})) return `AMX_SMIN;
    return v[`AMX_SW-1:0];
  endfunction

  // Sample times unsigned gain, full width
  function automatic logic signed [47:0] amx_mul(input amx_sample_t x, input amx_gain_t g);
    return 48'(x) * 48'($signed({1'b0, g}));
  endfunction

  // Magnitude as unsigned
  function automatic logic [`AMX_SW-1:0] amx_abs(input amx_sample_t x);
    return x[`AMX_SW-1] ? `AMX_SW'(-x) : `AMX_SW'(x);
  endfunction
endpackage

//--- design/amx_eq_stage.sv
// Per-channel tone stage: switchable low cut and three-band equaliser.
// Assumes step_in pulses once per sample frame; output is registered.
`timescale 1ns/1ns
`default_nettype none
`include "amx_params.svh"
module amx_eq_stage (
  input  wire logic                 clk_in,    // System clock
  input  wire logic                 nrst_in,   // Sync reset, low
  input  wire logic                 step_in,   // One pulse per frame
  input  wire amx_pkg::amx_sample_t x_in,      // Raw input sample
  input  wire amx_pkg::amx_gain_t   gl_in,     // Low band gain
  input  wire amx_pkg::amx_gain_t   gm_in,     // Mid band gain
  input  wire amx_pkg::amx_gain_t   gh_in,     // High band gain
  input  wire logic                 lowcut_in, // Low cut enable
  output amx_pkg::amx_sample_t      y_out      // Equalised sample
);
  import amx_pkg::*;
  logic signed [26:0] lc, lo, hi;                // Filter states
  logic signed [26:0] next_lc, next_lo, next_hi; // Next filter states
  logic signed [26:0] xw, xs;                    // Widened, low-cut input
  logic signed [47:0] sum;                       // Weighted band sum
  amx_sample_t        next_y;                    // Next output

  // Filters advance only on the frame pulse
  always_comb begin
    xw = 27'(x_in);
    xs = lowcut_in ? xw - lc : xw;
    next_lc = lc;
    next_lo = lo;
    next_hi = hi;
    next_y  = y_out;
    sum = amx_mul(amx_sat(48'(lo)), gl_in) + amx_mul(amx_sat(48'(hi - lo)), gm_in)
        + amx_mul(amx_sat(48'(xs - hi)), gh_in);
    if (step_in) begin
      next_lc = lc + ((xw - lc) >>> `AMX_LC_SHIFT);
      next_lo = lo + ((xs - lo) >>> `AMX_LO_SHIFT);
      next_hi = hi + ((xs - hi) >>> `AMX_HI_SHIFT);
      next_y  = amx_sat(sum >>> `AMX_GSHIFT);
    end
  end

  // State registers
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lc    <= '0;
      lo    <= '0;
      hi    <= '0;
      y_out <= '0;
    end else begin
      lc    <= next_lc;
      lo    <= next_lo;
      hi    <= next_hi;
      y_out <= next_y;
    end
  end
endmodule
`default_nettype wire

//--- design/amx_mixer.sv
// Audio matrix mixer: 12 inputs and 12 playbacks onto 12 outputs.
// Assumes one sample strobe per frame, at least 27 clocks apart.
// Functional notes
// - Twelve inputs, playbacks and outputs
// - Any input to any output, own gain
// - Any playback to any output, own gain
// - Six independent stereo submixes
// - One source, many outputs, own levels
// - Record path bypasses mixer normally
// - Peak and RMS on every channel
// - Input and playback meters pre-fader
// - Output meters after mix and gain
// - Per-output master level on sum
// - Three-band EQ, low cut, echo effect
// - Two-channel optical keeps outputs 0-5, mutes 6-11
// - Record EQ puts input EQ in record
`timescale 1ns/1ns
`default_nettype none
`include "amx_params.svh"
module amx_mixer #(
  parameter int FX_DEPTH = `AMX_FX_DEPTH     // Echo delay in frames
) (
  input  wire logic                  clk_in,          // 100 MHz clock
  input  wire logic                  nrst_in,         // Sync reset, low
  input  wire logic                  sample_valid_in, // Frame strobe
  input  wire amx_pkg::amx_frame_t   in_frame_in,     // Hardware inputs
  input  wire amx_pkg::amx_frame_t   pb_frame_in,     // Host playback
  input  wire amx_pkg::amx_reg_req_t reg_req_in,      // Register request
  output logic [31:0]                rd_data_out,     // Read data
  output amx_pkg::amx_frame_t        out_frame_out,   // Hardware outputs
  output amx_pkg::amx_frame_t        rec_frame_out,   // Record to host
  output logic                       frame_valid_out  // Outputs updated
);
  import amx_pkg::*;
  localparam int PW = $clog2(FX_DEPTH);

  // Software settings
  logic [3:0]  ctrl, next_ctrl;                       // Mode bits
  amx_gain_t   fx_snd, fx_ret, fx_fb;                 // Echo gains
  amx_gain_t   next_fx_snd, next_fx_ret, next_fx_fb;  // Next echo gains
  amx_gain_t   ogain [`AMX_NCH];                      // Output levels
  amx_gain_t   next_ogain [`AMX_NCH];                 // Next output levels
  amx_gain_t   eqg [`AMX_NCH][3];                     // Band gains
  amx_gain_t   next_eqg [`AMX_NCH][3];                // Next band gains
  logic [`AMX_NCH-1:0] lowcut, next_lowcut;           // Low cut enables
  amx_gain_t   xp [`AMX_NCH][`AMX_NSRC];              // Crosspoint gains
  amx_gain_t   next_xp [`AMX_NCH][`AMX_NSRC];         // Next crosspoints
  logic [31:0] next_rd;                               // Next read data
  // Mixing pipeline
  amx_state_t  state, next_state;                     // Sequencer
  logic [4:0]  src, next_src;                         // Source index
  amx_frame_t  in_q, pb_q, next_in_q, next_pb_q;      // Latched frame
  logic signed [47:0] acc [`AMX_NCH];                 // Output sums
  logic signed [47:0] next_acc [`AMX_NCH];            // Next sums
  logic signed [47:0] fx_acc, next_fx_acc, t;         // Echo send sum
  amx_frame_t  out_mix, next_mix;                     // Post-gain mix
  amx_frame_t  next_out, next_rec;                    // Next outputs
  logic        next_fv;                               // Next frame flag
  amx_sample_t dly [FX_DEPTH];                        // Echo delay line
  amx_sample_t next_dly [FX_DEPTH];                   // Next delay line
  logic [PW-1:0] fx_ptr, next_ptr;                    // Delay position
  logic [15:0] frame_cnt, next_cnt;                   // Frames mixed
  amx_sample_t s, echo, fx_in;                        // Source, taps
  // Meters
  logic [`AMX_SW-1:0] peak [`AMX_NMET];               // Peak holds
  logic [`AMX_SW-1:0] rms [`AMX_NMET];                // Mean squares
  logic [`AMX_SW-1:0] next_peak [`AMX_NMET];          // Next peaks
  logic [`AMX_SW-1:0] next_rms [`AMX_NMET];           // Next means
  logic [`AMX_SW-1:0] mabs, msq, mbase;               // Meter temps
  amx_sample_t        mv;                             // Metered sample
  logic signed [24:0] mdiff;                          // Mean update step
  amx_sample_t eq_y [`AMX_NCH];                       // EQ outputs
  logic        eq_step;                               // Frame accepted
  // Address decode
  logic [`AMX_AW-1:0] a, xpi, eqi;                    // Address, offsets
  logic        xp_hit, og_hit, eq_hit, pk_hit, rm_hit; // Range hits
  logic [15:0] wd;                                    // Low write data

  assign a   = reg_req_in.addr;
  assign wd  = reg_req_in.wdata[15:0];
  assign xpi = a - `AMX_BASE_XP;
  assign eqi = a - `AMX_BASE_EQ;
  assign xp_hit = (a >= `AMX_BASE_XP) && (a < `AMX_END_XP) && (xpi[4:0] < 5'(`AMX_NSRC));
  assign og_hit = (a >= `AMX_BASE_OGAIN) && (a < `AMX_BASE_OGAIN + 10'(`AMX_NCH));
  assign eq_hit = (a >= `AMX_BASE_EQ) && (a < `AMX_END_EQ);
  assign pk_hit = (a >= `AMX_BASE_PEAK) && (a < `AMX_BASE_PEAK + 10'(`AMX_NMET));
  assign rm_hit = (a >= `AMX_BASE_RMS) && (a < `AMX_BASE_RMS + 10'(`AMX_NMET));
  // EQ steps only on a frame strobe taken while the sequencer is idle
  assign eq_step = sample_valid_in && (state == AMX_IDLE);

  // one tone stage per input channel
  for (genvar g = 0; g < `AMX_NCH; g++) begin : g_eq
    amx_eq_stage u_eq (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .step_in   (eq_step),
      .x_in      (in_frame_in[g]),
      .gl_in     (eqg[g][0]),
      .gm_in     (eqg[g][1]),
      .gh_in     (eqg[g][2]),
      .lowcut_in (lowcut[g]),
      .y_out     (eq_y[g])
    );
  end

  // Register writes and read data
  always_comb begin
    next_ctrl   = ctrl;
    next_fx_snd = fx_snd;
    next_fx_ret = fx_ret;
    next_fx_fb  = fx_fb;
    next_ogain  = ogain;
    next_eqg    = eqg;
    next_lowcut = lowcut;
    next_xp     = xp;
    next_rd     = 32'h0;
    if (reg_req_in.wr) begin
      if (a == `AMX_REG_CTRL) next_ctrl = reg_req_in.wdata[3:0];
      if (a == `AMX_REG_FXSND) next_fx_snd = wd;
      if (a == `AMX_REG_FXRET) next_fx_ret = wd;
      if (a == `AMX_REG_FXFB) next_fx_fb = wd;
      if (og_hit) next_ogain[a[3:0]] = wd;
      if (eq_hit && eqi[1:0] == 2'h3) next_lowcut[eqi[5:2]] = reg_req_in.wdata[0];
      if (eq_hit && eqi[1:0] != 2'h3) next_eqg[eqi[5:2]][eqi[1:0]] = wd;
      if (xp_hit) next_xp[xpi[8:5]][xpi[4:0]] = wd;
    end
    if (reg_req_in.rd) begin
      if (a == `AMX_REG_CTRL) next_rd = 32'(ctrl);
      else if (a == `AMX_REG_STAT) next_rd = {frame_cnt, 15'h0, state != AMX_IDLE};
      else if (a == `AMX_REG_FXSND) next_rd = 32'(fx_snd);
      else if (a == `AMX_REG_FXRET) next_rd = 32'(fx_ret);
      else if (a == `AMX_REG_FXFB) next_rd = 32'(fx_fb);
      else if (og_hit) next_rd = 32'(ogain[a[3:0]]);
      else if (eq_hit && eqi[1:0] == 2'h3) next_rd = 32'(lowcut[eqi[5:2]]);
      else if (eq_hit) next_rd = 32'(eqg[eqi[5:2]][eqi[1:0]]);
      else if (pk_hit) next_rd = 32'(peak[a[5:0]]);
      else if (rm_hit) next_rd = 32'(rms[a[5:0]]);
      else if (xp_hit) next_rd = 32'(xp[xpi[8:5]][xpi[4:0]]);
    end
  end

  // Register file state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl        <= `AMX_CTRL_RST;
      fx_snd      <= `AMX_GAIN_RST;
      fx_ret      <= `AMX_GAIN_RST;
      fx_fb       <= `AMX_GAIN_RST;
      ogain       <= '{default: `AMX_UNITY};
      eqg         <= '{default: '{default: `AMX_UNITY}};
      lowcut      <= '0;
      xp          <= '{default: '{default: `AMX_GAIN_RST}};
      rd_data_out <= 32'h0;
    end else begin
      ctrl        <= next_ctrl;
      fx_snd      <= next_fx_snd;
      fx_ret      <= next_fx_ret;
      fx_fb       <= next_fx_fb;
      ogain       <= next_ogain;
      eqg         <= next_eqg;
      lowcut      <= next_lowcut;
      xp          <= next_xp;
      rd_data_out <= next_rd;
    end
  end

  // Mixing sequencer: latch, accumulate, level, publish
  always_comb begin
    next_state  = state;
    next_src    = src;
    next_in_q   = in_q;
    next_pb_q   = pb_q;
    next_acc    = acc;
    next_fx_acc = fx_acc;
    next_mix    = out_mix;
    next_out    = out_frame_out;
    next_rec    = rec_frame_out;
    next_fv     = 1'b0;
    next_dly    = dly;
    next_ptr    = fx_ptr;
    next_cnt    = frame_cnt;
    t           = '0;
    s     = (src < 5'(`AMX_NCH)) ? eq_y[src[3:0]] : pb_q[4'(src - 5'(`AMX_NCH))];
    echo  = dly[fx_ptr];
    fx_in = amx_sat(fx_acc >>> `AMX_GSHIFT);
    unique case (state)
      AMX_IDLE: begin
        // Frame taken only when idle
        if (sample_valid_in) begin
          next_in_q   = in_frame_in;
          next_pb_q   = pb_frame_in;
          next_acc    = '{default: '0};
          next_fx_acc = '0;
          next_src    = '0;
          next_state  = AMX_MIX;
        end
      end
      AMX_MIX: begin
        for (int o = 0; o < `AMX_NCH; o++) begin
          // each output its own gains
          next_acc[o] = acc[o] + amx_mul(s, xp[o][src]);
        end
        if (src < 5'(`AMX_NCH)) next_fx_acc = fx_acc + amx_mul(s, fx_snd);
        next_src = src + 5'h1;
        if (src == 5'(`AMX_NSRC - 1)) next_state = AMX_OUTG;
      end
      AMX_OUTG: begin
        for (int o = 0; o < `AMX_NCH; o++) begin
          t = 48'(amx_sat(acc[o] >>> `AMX_GSHIFT));
          if (ctrl[`AMX_CTRL_FX]) t = t + (amx_mul(echo, fx_ret) >>> `AMX_GSHIFT);
          next_mix[o] = amx_sat(amx_mul(amx_sat(t), ogain[o]) >>> `AMX_GSHIFT);
        end
        next_dly[fx_ptr] = amx_sat(48'(fx_in) + (amx_mul(echo, fx_fb) >>> `AMX_GSHIFT));
        next_ptr = (fx_ptr == PW'(FX_DEPTH - 1)) ? '0 : fx_ptr + 1'b1;
        next_state = AMX_DONE;
      end
      AMX_DONE: begin
        for (int o = 0; o < `AMX_NCH; o++) begin
          if (ctrl[`AMX_CTRL_SPDIF] && o >= `AMX_OPT_BASE + `AMX_OPT_KEEP) next_out[o] = '0;
          else next_out[o] = out_mix[o];
          if (ctrl[`AMX_CTRL_LOOP]) next_rec[o] = out_mix[o];
          else if (ctrl[`AMX_CTRL_RECEQ]) next_rec[o] = eq_y[o];
          else next_rec[o] = in_q[o];
        end
        next_fv    = 1'b1;
        next_cnt   = frame_cnt + 16'h1;
        next_state = AMX_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state           <= AMX_IDLE;
      src             <= '0;
      in_q            <= '0;
      pb_q            <= '0;
      acc             <= '{default: '0};
      fx_acc          <= '0;
      out_mix         <= '0;
      out_frame_out   <= '0;
      rec_frame_out   <= '0;
      frame_valid_out <= 1'b0;
      dly             <= '{default: '0};
      fx_ptr          <= '0;
      frame_cnt       <= '0;
    end else begin
      state           <= next_state;
      src             <= next_src;
      in_q            <= next_in_q;
      pb_q            <= next_pb_q;
      acc             <= next_acc;
      fx_acc          <= next_fx_acc;
      out_mix         <= next_mix;
      out_frame_out   <= next_out;
      rec_frame_out   <= next_rec;
      frame_valid_out <= next_fv;
      dly             <= next_dly;
      fx_ptr          <= next_ptr;
      frame_cnt       <= next_cnt;
    end
  end

  // Meters: 0-11 inputs, 12-23 playback, 24-35 outputs
  always_comb begin
    next_peak = peak;
    next_rms  = rms;
    mv        = '0;
    mabs      = '0;
    msq       = '0;
    mbase     = '0;
    mdiff     = '0;
    for (int m = 0; m < `AMX_NMET; m++) begin
      if (m < `AMX_NCH) mv = in_q[m];
      else if (m < 2 * `AMX_NCH) mv = pb_q[m - `AMX_NCH];
      else mv = out_mix[m - 2 * `AMX_NCH];
      mabs  = amx_abs(mv);
      msq   = `AMX_SW'((48'(mabs) * 48'(mabs)) >> `AMX_SQSHIFT);
      // Read clears the peak; new sample still lands
      mbase = (reg_req_in.rd && pk_hit && a[5:0] == 6'(m)) ? '0 : peak[m];
      next_peak[m] = mbase;
      if (state == AMX_DONE) begin
        if (mabs > mbase) next_peak[m] = mabs;
        mdiff = $signed({1'b0, msq}) - $signed({1'b0, rms[m]});
        next_rms[m] = `AMX_SW'($signed({1'b0, rms[m]}) + (mdiff >>> `AMX_RMS_SHIFT));
      end
    end
  end

  // Meter state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      peak <= '{default: '0};
      rms  <= '{default: '0};
    end else begin
      peak <= next_peak;
      rms  <= next_rms;
    end
  end

  // Checks
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_frame_latency : assert property (
    (state == AMX_IDLE && sample_valid_in) |-> ##27 frame_valid_out)
    else $error("Frame result not published on time");
  a_busy_ignore : assert property (
    (state != AMX_IDLE && sample_valid_in) |=> $stable(in_q) && $stable(pb_q))
    else $error("Frame accepted while busy");
  a_xp_write : assert property (
    (reg_req_in.wr && a == `AMX_BASE_XP) |=> xp[0][0] == $past(wd))
    else $error("Crosspoint gain not stored");
  a_rec_raw : assert property (
    (frame_valid_out && ($past(ctrl) & 4'h3) == 4'h0) |-> rec_frame_out == in_q)
    else $error("Record path altered without a mode");
  a_rec_loop : assert property (
    (frame_valid_out && ctrl[`AMX_CTRL_LOOP] && $stable(ctrl))
     |-> rec_frame_out == out_mix)
    else $error("Loopback record differs from mix");
  a_rec_eq : assert property (
    (frame_valid_out && $stable(ctrl) && ctrl == 4'h1) |-> rec_frame_out[0] == eq_y[0]
      && rec_frame_out[11] == eq_y[11])
    else $error("Record path not equalised");
  a_opt_mute : assert property (
    (frame_valid_out && $stable(ctrl) && ctrl[`AMX_CTRL_SPDIF]) |-> out_frame_out[6] == '0
      && out_frame_out[5] == out_mix[5] && out_frame_out[11] == '0)
    else $error("Optical channel mute wrong");
  a_peak_pre : assert property (
    frame_valid_out |-> peak[0] >= amx_abs(in_q[0]) && peak[12] >= amx_abs(pb_q[0]))
    else $error("Input meter missed a peak");
  a_peak_post : assert property (
    frame_valid_out |-> peak[24] >= amx_abs(out_mix[0]))
    else $error("Output meter missed a peak");
  a_sum_clip : assert property (
    (state == AMX_OUTG && !ctrl[`AMX_CTRL_FX] && ogain[2] == `AMX_UNITY
     && (acc[2] >>> `AMX_GSHIFT) > 48'sh7FFFFF) |=> out_mix[2] == `AMX_SMAX)
    else $error("Output sum wrapped");

  c_frame  : cover property (frame_valid_out);
  c_loop   : cover property (frame_valid_out && ctrl[`AMX_CTRL_LOOP]);
  c_spdif  : cover property (frame_valid_out && ctrl[`AMX_CTRL_SPDIF]);
  c_clip   : cover property (state == AMX_DONE && out_mix[2] == `AMX_SMAX);
endmodule
`default_nettype wire

//--- tb/amx_src_model.sv
// Partner model: converters and host playback that feed the mixer frames.
// Assumes the bench raises go_in for one cycle for each frame it wants sent.
`timescale 1ns/1ns
`default_nettype none
module amx_src_model (
  input  wire logic                go_in,      // Request one frame
  input  wire amx_pkg::amx_frame_t in_data_in, // Converter samples
  input  wire amx_pkg::amx_frame_t pb_data_in, // Playback samples
  output logic                     strobe_out, // Frame strobe
  output amx_pkg::amx_frame_t      in_out,     // Converter lines
  output amx_pkg::amx_frame_t      pb_out      // Playback lines
);
  import amx_pkg::*;
  // twelve channels each way
  // Lines carry data only with the strobe; inverted otherwise, so late sampling shows
  always_comb begin
    strobe_out = go_in;
    in_out     = go_in ? in_data_in : ~in_data_in;
    pb_out     = go_in ? pb_data_in : ~pb_data_in;
  end
endmodule
`default_nettype wire

//--- tb/amx_mixer_tb.sv
// Self-checking bench for the audio matrix mixer.
// Assumes the partner model supplies frames; expectations use exact gains only.
`timescale 1ns/1ns
`default_nettype none
`include "amx_params.svh"
module amx_mixer_tb;
  import amx_pkg::*;
  logic         clk_in = 1'b0;
  logic         nrst_in = 1'b0;
  logic         go = 1'b0;
  logic         fv;
  logic         sv;
  logic [31:0]  rdd;
  logic [31:0]  d;
  amx_reg_req_t req = '0;
  amx_frame_t   ind = '0;
  amx_frame_t   pbd = '0;
  amx_frame_t   inl, pbl, outf, recf, ef;
  amx_gain_t    xg [12][24]; // Mirror of crosspoint gains
  amx_gain_t    og [12];     // Mirror of output gains
  logic [23:0]  rm0 = '0;    // Mirror of input 0 mean square
  int           n_fail = 0;
  int           num_checks = 0;
  always #5 clk_in = ~clk_in;
  amx_src_model i_amx_src_model (.go_in(go), .in_data_in(ind), .pb_data_in(pbd),
    .strobe_out(sv), .in_out(inl), .pb_out(pbl));
  amx_mixer #(.FX_DEPTH(4)) i_amx_mixer (.clk_in(clk_in), .nrst_in(nrst_in),
    .sample_valid_in(sv), .in_frame_in(inl), .pb_frame_in(pbl), .reg_req_in(req),
    .rd_data_out(rdd), .out_frame_out(outf), .rec_frame_out(recf), .frame_valid_out(fv));
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [287:0] seen, input logic [287:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge clk_in);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1 d = rdd;
  endtask
  task automatic xp(input int o, input int s, input amx_gain_t g);
    xg[o][s] = g;
    wr(10'(`AMX_BASE_XP + o * 32 + s), 32'(g));
  endtask
  // Strobe one frame, optionally a refused strobe while busy, then wait for the pulse
  task automatic frame(input amx_frame_t i, input amx_frame_t p, input bit stray = 1'b0);
    int n;
    @(posedge clk_in);
    ind <= i;
    pbd <= p;
    go <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      go <= stray && (n == 8);
      n++;
      #1;
    end while (fv !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      summarize();
    end
    chk("latency", 32'(n), 32'd27);
    rm0 = rstep(rm0, i[0]);
  endtask
  function automatic amx_sample_t sat(input longint v);
    if (v > 64'sh7FFFFF) return `AMX_SMAX;
    if (v < -64'sh800000) return `AMX_SMIN;
    return v[23:0];
  endfunction
  // Expected outputs from playback sources, crosspoints and output gains
  function automatic amx_frame_t mix(input amx_frame_t p);
    amx_frame_t r;
    longint     acc;
    for (int o = 0; o < 12; o++) begin
      acc = 0;
      for (int s = 0; s < 12; s++) acc += (longint'(p[s]) * longint'(xg[o][12 + s])) >>> 15;
      r[o] = sat((longint'(sat(acc)) * longint'(og[o])) >>> 15);
    end
    return r;
  endfunction
  function automatic logic [31:0] mag(input amx_sample_t x);
    return 32'(x[23] ? 24'(-x) : 24'(x));
  endfunction
  // Leaky mean of the scaled square, one step per frame
  function automatic logic [23:0] rstep(input logic [23:0] r, input amx_sample_t x);
    longint q;
    q = (longint'(mag(x)) * longint'(mag(x))) >>> 23;
    return 24'(longint'(r) + ((q - longint'(r)) >>> 8));
  endfunction
  function automatic amx_frame_t rnd();
    amx_frame_t r;
    for (int c = 0; c < 12; c++) r[c] = amx_sample_t'($urandom & 32'hFFFFFE);
    return r;
  endfunction
  // Main sequence
  initial begin
    amx_frame_t a, b;
    void'($urandom(86847));
    foreach (og[o]) og[o] = `AMX_UNITY;
    foreach (xg[o, s]) xg[o][s] = `AMX_GAIN_RST;
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(10'h3FF);
    chk("unmapped", d, 0);
    rd(`AMX_REG_CTRL);
    chk("ctrl reset", d, 0);
    for (int o = 0; o < 12; o++) xp(o, 12 + (o * 5 + 3) % 12, `AMX_UNITY);
    xp(6, 15, 16'h4000);
    xp(0, 0, 16'h1234);
    rd(`AMX_BASE_XP);
    chk("xp readback", d, 32'h1234);
    xp(0, 0, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      a = rnd();
      b = rnd();
      frame(a, b, k == 1);
      chk("outputs", outf, mix(b));
      chk("record", recf, a);
    end
    wr(`AMX_BASE_OGAIN + 10'h1, 32'h0);
    og[1] = 16'h0000;
    rd(`AMX_BASE_PEAK + 10'h3);
    rd(`AMX_BASE_PEAK + 10'h11);
    rd(`AMX_BASE_PEAK + 10'h19);
    rd(`AMX_BASE_PEAK + 10'h1A);
    a = rnd();
    b = rnd();
    frame(a, b);
    chk("muted out", outf, mix(b));
    rd(`AMX_BASE_PEAK + 10'h3);
    chk("in peak", d, mag(a[3]));
    rd(`AMX_BASE_PEAK + 10'h11);
    chk("pb peak", d, mag(b[5]));
    rd(`AMX_BASE_PEAK + 10'h19);
    chk("out1 peak", d, 0);
    rd(`AMX_BASE_PEAK + 10'h1A);
    ef = mix(b);
    chk("out2 peak", d, mag(ef[2]));
    xp(2, 12, `AMX_UNITY);
    xp(3, 19, `AMX_UNITY);
    b[0] = 24'h700000;
    b[1] = 24'h700000;
    b[6] = 24'h900000;
    b[7] = 24'h900000;
    frame(a, b);
    chk("sat high", $unsigned(outf[2]), `AMX_SMAX);
    chk("sat low", $unsigned(outf[3]), `AMX_SMIN);
    wr(`AMX_REG_CTRL, 32'h2);
    b = rnd();
    frame(a, b);
    chk("loopback", recf, mix(b));
    wr(`AMX_REG_CTRL, 32'h4);
    frame(a, b);
    ef = mix(b);
    for (int c = 6; c < 12; c++) ef[c] = '0;
    chk("two channel", outf, ef);
    chk("record back", recf, a);
    wr(`AMX_BASE_EQ, 32'h0);
    wr(`AMX_BASE_EQ + 10'h1, 32'h0);
    wr(`AMX_BASE_EQ + 10'h2, 32'h0);
    wr(`AMX_REG_CTRL, 32'h1);
    a = rnd();
    frame(a, b);
    chk("record eq", recf[0], 0);
    chk("eq outputs", outf, mix(b));
    rd(`AMX_BASE_RMS);
    chk("in rms", d, 32'(rm0));
    summarize();
  end
endmodule
`default_nettype wire
